/* isfl_bus_master.sv */
// isfl_bus_master.sv: two-wire bus master model driving scl and sda.
// assumes pull-ups on both lines, so a released line reads 1.
`timescale 1ns/10ps
`default_nettype none
module isfl_bus_master (
    // bus levels
    output logic scl,
    output logic sda
);
    localparam realtime QTR = 31.25; // quarter of the 125 ns link period
    // bus idles high; the clock stands still outside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // start or repeated start, leaves scl low
    task automatic start_cond();
        sda = 1'b1;
        #(QTR) scl = 1'b1;
        #(QTR) sda = 1'b0;
        #(QTR) scl = 1'b0;
        #(QTR);
    endtask
    // one clocked bit; a 1 is the released line
    task automatic clk_bit(input logic b);
        sda = b;
        #(QTR) scl = 1'b1;
        #(2 * QTR) scl = 1'b0;
        #(QTR);
    endtask
    // stop, leaves the bus idle
    task automatic stop_cond();
        sda = 1'b0;
        #(QTR) scl = 1'b1;
        #(QTR) sda = 1'b1;
        #(QTR);
    endtask
endmodule
`default_nettype wire

/* isfl_cfg.svh */
// isfl_cfg.svh: named constants of the serial bus status-flag block.
// assumes a 32-bit apb with byte addresses; included by bare name.
`ifndef ISFL_CFG_SVH
`define ISFL_CFG_SVH
// register byte offsets
`define ISFL_OFF_STATUS 8'h00
`define ISFL_OFF_CTRL1 8'h04
`define ISFL_OFF_CTRL2 8'h08
`define ISFL_OFF_SMBC 8'h0c
`define ISFL_OFF_ADDR1 8'h10
`define ISFL_OFF_RANGE 8'h14
`define ISFL_OFF_ADDR2 8'h18
`define ISFL_OFF_DATA 8'h1c
`define ISFL_OFF_IRQST 8'h20
`define ISFL_OFF_IRQMSK 8'h24
// field positions
`define ISFL_CTRL1_TX 4
`define ISFL_CTRL2_GENERAL_CALL_ENABLE 7
`define ISFL_CTRL2_RANGE_MATCH_ENABLE 3
`define ISFL_CTRL2_BUFMODE 0
`define ISFL_SMBC_ALERT 7
`define ISFL_SMBC_SECOND 6
// interrupt status bit positions
`define ISFL_IRQ_DONE 0
`define ISFL_IRQ_ADDR 1
`define ISFL_IRQ_START 2
`define ISFL_IRQ_STOP 3
// bus constants
`define ISFL_ALERT_ADDR 7'h0c
`define ISFL_GCALL_ADDR 7'h00
`define ISFL_BIT_LAST 4'h7
`define ISFL_BIT_ACK 4'h8
`define ISFL_BIT_END 4'h9
// reset values
`define ISFL_RST_BYTE 8'h00
`define ISFL_RST_IRQ 4'h0
`endif

/* isfl_pkg.sv */
// isfl_pkg.sv: types of the serial bus status-flag block.
// assumes isfl_cfg.svh for all numeric constants.
`default_nettype none
package isfl_pkg;
    // apb request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } isfl_apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } isfl_apb_rsp_s;
    // raw two-wire pin levels
    typedef struct packed {
        logic scl;
        logic sda;
    } isfl_pins_s;
    // which byte of a frame is on the wire
    typedef enum logic [1:0] {
        ISFL_PH_IDLE = 2'b00,
        ISFL_PH_ADDR = 2'b01,
        ISFL_PH_DATA = 2'b10
    } isfl_phase_e;
endpackage
`default_nettype wire

/* isfl_status_flags.sv */
// isfl_status_flags.sv: status flags of a two-wire serial controller with apb access.
// assumes raw scl/sda pin levels (asynchronous) and internal data-access strobes on core_clk.
//
// Behaviour
// - in buffered mode an internal data-register access clears transfer complete.
// - transfer complete reads 0 during a byte and 1 after; status bit 7.
// - addressed flag (bit 6) sets on primary match or nonzero range match.
// - addressed flag sets on general call when general call is enabled.
// - addressed flag sets on second address match when that is enabled.
// - addressed flag sets on alert response address when alert is enabled.
// - with range matching, addresses between primary and range values match.
// - addressed flag is set before the acknowledge bit of the address.
// - any write to the first control register clears the addressed flag; an address match in the same cycle keeps it set.
// - addressed flag reads 0 when not addressed, 1 when addressed.
// - bus busy (bit 5) sets on start, clears on stop, any mode.
// - transfer complete sets at byte end; cleared by matching software data access outside buffered mode.
// - read/write bit of the matched calling address is shown as indication.
`timescale 1ns/10ps
`default_nettype none
`include "isfl_cfg.svh"
module isfl_status_flags (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire isfl_pkg::isfl_apb_req_s apb_req,
    output var isfl_pkg::isfl_apb_rsp_s apb_rsp,
    // serial bus pins
    input wire isfl_pkg::isfl_pins_s pins,
    // internal data-register strobe of buffered operation
    input wire logic int_data_access,
    // interrupt
    output logic irq
);
    import isfl_pkg::*;

    // address decode
    function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] p, input logic [6:0] r,
                                      input logic [6:0] s, input logic [7:0] c2, input logic [7:0] system_mgmt_bus_control_reg);
        logic range_match_enable;
        range_match_enable = c2[`ISFL_CTRL2_RANGE_MATCH_ENABLE];
        addr_hit = (a == p)
            || (range_match_enable && (r != 7'h00) && (a == r))
            || (c2[`ISFL_CTRL2_GENERAL_CALL_ENABLE] && (a == `ISFL_GCALL_ADDR))
            || (system_mgmt_bus_control_reg[`ISFL_SMBC_SECOND] && (a == s))
            || (system_mgmt_bus_control_reg[`ISFL_SMBC_ALERT] && (a == `ISFL_ALERT_ADDR))
            || (range_match_enable && (a > p) && (a < r));
    endfunction

    // pin synchronisers and edge history
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else if (ce) begin
            {scl_m_q, scl_s_q, scl_p_q} <= {pins.scl, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {pins.sda, sda_m_q, sda_s_q};
        end
    end

    // bus conditions
    wire scl_rise = scl_s_q && !scl_p_q;
    wire scl_fall = !scl_s_q && scl_p_q;
    wire start_det = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
    wire stop_det = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

    // software registers and flags
    logic [7:0] ctrl1_q, ctrl2_q, smbc_q;
    logic [6:0] addr1_q, range_q, addr2_q;
    logic [3:0] irq_stat_q, irq_mask_q;
    logic tcf_q, tcf_d, addressed_as_target_flag_q, addressed_as_target_flag_d, busy_q, busy_d, srw_q, hit_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    isfl_phase_e phase_q, phase_d;

    // apb decode
    wire apb_setup = apb_req.psel && !apb_req.penable;
    wire apb_done = apb_req.psel && apb_req.penable && apb_rsp.pready;
    wire wr_done = apb_done && apb_req.pwrite;
    wire rd_done = apb_done && !apb_req.pwrite;
    wire sel_status = apb_req.paddr == `ISFL_OFF_STATUS;
    wire sel_ctrl1 = apb_req.paddr == `ISFL_OFF_CTRL1;
    wire sel_ctrl2 = apb_req.paddr == `ISFL_OFF_CTRL2;
    wire sel_smbc = apb_req.paddr == `ISFL_OFF_SMBC;
    wire sel_addr1 = apb_req.paddr == `ISFL_OFF_ADDR1;
    wire sel_range = apb_req.paddr == `ISFL_OFF_RANGE;
    wire sel_addr2 = apb_req.paddr == `ISFL_OFF_ADDR2;
    wire sel_data = apb_req.paddr == `ISFL_OFF_DATA;
    wire sel_irqst = apb_req.paddr == `ISFL_OFF_IRQST;
    wire sel_irqmsk = apb_req.paddr == `ISFL_OFF_IRQMSK;
    wire sel_any = sel_status || sel_ctrl1 || sel_ctrl2 || sel_smbc || sel_addr1 || sel_range
        || sel_addr2 || sel_data || sel_irqst || sel_irqmsk;
    wire ctrl1_wr = wr_done && sel_ctrl1;
    wire tx_mode = ctrl1_q[`ISFL_CTRL1_TX];
    wire buf_mode = ctrl2_q[`ISFL_CTRL2_BUFMODE];

    // read mux
    wire [7:0] status_byte = {tcf_q, addressed_as_target_flag_q, busy_q, 2'h0, srw_q, 2'h0};
    wire [7:0] rd_byte =
        sel_status ? status_byte :
        sel_ctrl1 ? ctrl1_q :
        sel_ctrl2 ? ctrl2_q :
        sel_smbc ? smbc_q :
        sel_addr1 ? {1'b0, addr1_q} :
        sel_range ? {1'b0, range_q} :
        sel_addr2 ? {1'b0, addr2_q} :
        sel_data ? shift_q :
        sel_irqst ? {4'h0, irq_stat_q} :
        sel_irqmsk ? {4'h0, irq_mask_q} : 8'h00;

    // byte framing
    wire bit_sample = scl_rise && (bit_cnt_q <= `ISFL_BIT_LAST) && (phase_q != ISFL_PH_IDLE);
    wire [7:0] shift_d = bit_sample ? {shift_q[6:0], sda_s_q} : shift_q;
    wire addr_done = bit_sample && (bit_cnt_q == `ISFL_BIT_LAST) && (phase_q == ISFL_PH_ADDR);
    wire addr_match = addr_done && addr_hit(shift_d[7:1], addr1_q, range_q, addr2_q, ctrl2_q, smbc_q);
    wire byte_done = scl_fall && (bit_cnt_q == `ISFL_BIT_END);

    // data-register access that clears transfer complete
    wire sw_data_clr = sel_data && ((rd_done && !tx_mode) || (wr_done && tx_mode));
    wire tcf_clr = buf_mode ? int_data_access : sw_data_clr;

    // next flag values, setting wins over clearing
    always_comb begin
        tcf_d = tcf_q;
        if (tcf_clr) tcf_d = 1'b0;
        if (byte_done) tcf_d = 1'b1;
        addressed_as_target_flag_d = addressed_as_target_flag_q;
        if (ctrl1_wr) addressed_as_target_flag_d = 1'b0;
        if (addr_match) addressed_as_target_flag_d = 1'b1;
        busy_d = busy_q;
        if (stop_det) busy_d = 1'b0;
        if (start_det) busy_d = 1'b1;
        phase_d = phase_q;
        unique case (phase_q)
            ISFL_PH_IDLE: phase_d = start_det ? ISFL_PH_ADDR : ISFL_PH_IDLE;
            ISFL_PH_ADDR: phase_d = byte_done ? ISFL_PH_DATA : ISFL_PH_ADDR;
            ISFL_PH_DATA: phase_d = ISFL_PH_DATA;
            default: phase_d = ISFL_PH_IDLE;
        endcase
        if (start_det) phase_d = ISFL_PH_ADDR;                 // repeated start restarts address
        if (stop_det) phase_d = ISFL_PH_IDLE;
    end

    // flag and framing state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {tcf_q, addressed_as_target_flag_q, busy_q, srw_q, hit_q} <= 5'h00;
            phase_q <= ISFL_PH_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= `ISFL_RST_BYTE;
        end else if (ce) begin
            tcf_q <= tcf_d;
            addressed_as_target_flag_q <= addressed_as_target_flag_d;
            busy_q <= busy_d;
            phase_q <= phase_d;
            shift_q <= shift_d;
            if (addr_match) srw_q <= shift_d[0];
            if (addr_done) hit_q <= addr_match;
            if (start_det || stop_det || byte_done) bit_cnt_q <= 4'h0;
            else if (scl_rise && phase_q != ISFL_PH_IDLE) bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // software registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {ctrl1_q, ctrl2_q, smbc_q} <= {3{`ISFL_RST_BYTE}};
            {addr1_q, range_q, addr2_q} <= 21'h0;
            irq_mask_q <= `ISFL_RST_IRQ;
        end else if (ce && wr_done) begin
            if (sel_ctrl1) ctrl1_q <= apb_req.pwdata[7:0];   // direction set by software
            if (sel_ctrl2) ctrl2_q <= apb_req.pwdata[7:0];
            if (sel_smbc) smbc_q <= apb_req.pwdata[7:0];
            if (sel_addr1) addr1_q <= apb_req.pwdata[6:0];
            if (sel_range) range_q <= apb_req.pwdata[6:0];
            if (sel_addr2) addr2_q <= apb_req.pwdata[6:0];
            if (sel_irqmsk) irq_mask_q <= apb_req.pwdata[3:0];
        end
    end

    // sticky events, cleared by reading them, new events win
    wire [3:0] irq_ev = {stop_det, start_det, addr_match, byte_done};
    wire irq_rd = rd_done && sel_irqst;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_stat_q <= `ISFL_RST_IRQ;
            irq <= 1'b0;
        end else if (ce) begin
            irq_stat_q <= (irq_rd ? 4'h0 : irq_stat_q) | irq_ev;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // apb answer: one wait state, read data latched in the setup cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            apb_rsp <= '0;
        end else if (ce) begin
            apb_rsp.pready <= apb_req.psel && apb_req.penable && !apb_rsp.pready;
            if (apb_setup) begin
                apb_rsp.prdata <= {24'h0, rd_byte};
                apb_rsp.pslverr <= !sel_any;
            end
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_ctrl1_clears;
        ce && ctrl1_wr && !addr_match |=> !addressed_as_target_flag_q;
    endproperty
    a_ctrl1_clears: assert property (p_ctrl1_clears) else $error("addressed flag not cleared");

    property p_busy_set;
        ce && start_det |=> busy_q;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set on start");

    property p_busy_clr;
        ce && stop_det && !start_det |=> !busy_q;
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared on stop");

    property p_primary_match;
        ce && addr_done && (shift_d[7:1] == addr1_q) |=> addressed_as_target_flag_q && srw_q == $past(sda_s_q);
    endproperty
    a_primary_match: assert property (p_primary_match) else $error("primary match missed");

    property p_tcf_set;
        ce && byte_done |=> tcf_q;
    endproperty
    a_tcf_set: assert property (p_tcf_set) else $error("transfer complete not set");

    property p_buf_clear;
        ce && buf_mode && int_data_access && !byte_done |=> !tcf_q;
    endproperty
    a_buf_clear: assert property (p_buf_clear) else $error("buffered clear missed");

    property p_before_ack;
        ce && scl_rise && bit_cnt_q == `ISFL_BIT_ACK && phase_q == ISFL_PH_ADDR && hit_q
            && !$past(ctrl1_wr) && !ctrl1_wr |-> addressed_as_target_flag_q;
    endproperty
    a_before_ack: assert property (p_before_ack) else $error("flag late for acknowledge");

    property p_reset_idle;
        disable iff (1'b0) rst |=> !addressed_as_target_flag_q && !busy_q;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("flags not cleared by reset");

    property p_irq_level;
        ce && (irq_stat_q & irq_mask_q) != 4'h0 |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

    property p_general_call;
        ce && addr_done && ctrl2_q[`ISFL_CTRL2_GENERAL_CALL_ENABLE] && (shift_d[7:1] == `ISFL_GCALL_ADDR) |=> addressed_as_target_flag_q;
    endproperty
    a_general_call: assert property (p_general_call) else $error("general call missed");

    property p_second_match;
        ce && addr_done && smbc_q[`ISFL_SMBC_SECOND] && (shift_d[7:1] == addr2_q) |=> addressed_as_target_flag_q;
    endproperty
    a_second_match: assert property (p_second_match) else $error("second address missed");

    property p_alert_match;
        ce && addr_done && smbc_q[`ISFL_SMBC_ALERT] && (shift_d[7:1] == `ISFL_ALERT_ADDR) |=> addressed_as_target_flag_q;
    endproperty
    a_alert_match: assert property (p_alert_match) else $error("alert response missed");

    property p_range_match;
        ce && addr_done && ctrl2_q[`ISFL_CTRL2_RANGE_MATCH_ENABLE] && (((shift_d[7:1] > addr1_q) && (shift_d[7:1] < range_q))
            || ((range_q != 7'h00) && (shift_d[7:1] == range_q))) |=> addressed_as_target_flag_q;
    endproperty
    a_range_match: assert property (p_range_match) else $error("range match missed");

    property p_stay_clear;
        ce && !addr_match && !addressed_as_target_flag_q |=> !addressed_as_target_flag_q;
    endproperty
    a_stay_clear: assert property (p_stay_clear) else $error("addressed flag set unaddressed");

    property p_sw_clear;
        ce && !buf_mode && rd_done && sel_data && !tx_mode && !byte_done |=> !tcf_q;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("data read left flag set");

    property p_srw_shown;
        ce && addr_match |=> srw_q == $past(shift_d[0]);
    endproperty
    a_srw_shown: assert property (p_srw_shown) else $error("read/write indication wrong");

    property p_status_read;
        ce && apb_setup && sel_status |=> apb_rsp.prdata[7:5] == $past({tcf_q, addressed_as_target_flag_q, busy_q});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_irq_clear;
        ce && irq_rd && (irq_ev == 4'h0) |=> irq_stat_q == 4'h0;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt status not cleared");

    c_addressed: cover property (ce && addr_match);
    c_byte_done: cover property (ce && byte_done && tcf_q == 1'b0);
    c_stop: cover property (ce && stop_det && busy_q);
    c_range: cover property (ce && addr_match && ctrl2_q[`ISFL_CTRL2_RANGE_MATCH_ENABLE]);
endmodule
`default_nettype wire

/* isfl_status_flags_test.sv */
// isfl_status_flags_test.sv: self-checking bench of the status-flag block.
// assumes isfl_bus_master on the pins and apb byte addresses from isfl_cfg.svh.
`timescale 1ns/10ps
`default_nettype none
`include "isfl_cfg.svh"
module isfl_status_flags_test;
    import isfl_pkg::*;
    typedef struct packed {logic rd; logic err; logic [7:0] msk; logic [7:0] dat;} isfl_exp_s;
    typedef struct packed {
        logic [7:0] c2; logic [7:0] system_mgmt_bus_control_reg; logic [6:0] a1; logic [6:0] ra; logic [6:0] a2; logic [6:0] sent; logic hit;
    } isfl_case_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic int_data_access = 1'b0;
    logic irq;
    logic scl;
    logic sda;
    isfl_apb_req_s apb_req = '0;
    isfl_apb_rsp_s apb_rsp;
    isfl_pins_s pins;
    isfl_exp_s exp_q[$];
    isfl_exp_s mon_e;
    int err_total = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'ha65e204a;
    // address match table: ctrl2, smbc, primary, range, second, sent, hit
    isfl_case_s cases [11] = '{
        '{8'h00, 8'h00, 7'h2a, 7'h00, 7'h00, 7'h2a, 1'b1}, '{8'h00, 8'h00, 7'h2a, 7'h00, 7'h00, 7'h2b, 1'b0},
        '{8'h80, 8'h00, 7'h2a, 7'h00, 7'h00, 7'h00, 1'b1}, '{8'h00, 8'h00, 7'h2a, 7'h00, 7'h00, 7'h00, 1'b0},
        '{8'h00, 8'h40, 7'h2a, 7'h00, 7'h51, 7'h51, 1'b1}, '{8'h00, 8'h00, 7'h2a, 7'h00, 7'h51, 7'h51, 1'b0},
        '{8'h00, 8'h80, 7'h2a, 7'h00, 7'h00, 7'h0c, 1'b1}, '{8'h00, 8'h00, 7'h2a, 7'h00, 7'h00, 7'h0c, 1'b0},
        '{8'h08, 8'h00, 7'h20, 7'h30, 7'h00, 7'h30, 1'b1}, '{8'h08, 8'h00, 7'h20, 7'h30, 7'h00, 7'h28, 1'b1},
        '{8'h00, 8'h00, 7'h20, 7'h30, 7'h00, 7'h28, 1'b0}};
    assign pins = {scl, sda};
    // block under test and the far bus master
    isfl_status_flags i_isfl_status_flags (.core_clk(core_clk), .rst(rst), .ce(1'b1), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .pins(pins), .int_data_access(int_data_access), .irq(irq));
    isfl_bus_master i_isfl_bus_master (.scl(scl), .sda(sda));
    // clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one apb transfer; the expected answer goes to the queue first
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m, input logic e);
        int n;
        exp_q.push_back('{rd: !wr, err: e, msk: m, dat: d});
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {seed[31:8], d}};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge core_clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (n == 16) begin
            check("pready wait", 1'b0, 1'b1);
            conclude();
        end
        apb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 8'h00, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask
    // start plus an address byte, stopping before the acknowledge clock
    task automatic addr_byte(input logic [6:0] a, input logic rw);
        i_isfl_bus_master.start_cond();
        for (int i = 6; i >= 0; i--) i_isfl_bus_master.clk_bit(a[i]);
        i_isfl_bus_master.clk_bit(rw);
    endtask
    task automatic data_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) i_isfl_bus_master.clk_bit(b[i]);
        i_isfl_bus_master.clk_bit(1'b1);
    endtask
    // pairs each completed transfer with the oldest expectation
    always @(posedge core_clk) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
            mon_e = exp_q.pop_front();
            check("pslverr", apb_rsp.pslverr, mon_e.err);
            if (mon_e.rd) check("prdata", apb_rsp.prdata & {24'hffffff, mon_e.msk}, {24'h0, mon_e.dat & mon_e.msk});
        end
    end
    // watchdog
    initial begin
        #400000;
        check("run time", 1'b0, 1'b1);
        conclude();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(`ISFL_OFF_STATUS, 8'h00, 8'hff);
        rd(`ISFL_OFF_IRQST, 8'h00, 8'hff);
        apb(1'b0, 8'h3c, 8'h00, 8'hff, 1'b1);
        $display("test reset done");
        wr(`ISFL_OFF_ADDR1, 8'h2a);
        wr(`ISFL_OFF_IRQMSK, 8'h02);
        addr_byte(7'h2a, 1'b1);
        rd(`ISFL_OFF_STATUS, 8'h64, 8'hff);
        check("irq", irq, 1'b1); // addressed event unmasked
        i_isfl_bus_master.clk_bit(1'b1);
        rd(`ISFL_OFF_STATUS, 8'he4, 8'hff);
        rd(`ISFL_OFF_IRQST, 8'h07, 8'hff);
        rd(`ISFL_OFF_IRQST, 8'h00, 8'hff);
        check("irq", irq, 1'b0); // status cleared by the read
        $display("test addressing done");
        seed = xs(seed);
        wr(`ISFL_OFF_CTRL1, {seed[7:5], 1'b1, seed[3:0]}); // transmit, as the read indication asks
        rd(`ISFL_OFF_STATUS, 8'ha0, 8'he0);
        wr(`ISFL_OFF_DATA, seed[23:16]);
        rd(`ISFL_OFF_STATUS, 8'h20, 8'he0);
        data_byte(seed[15:8]);
        check("irq", irq, 1'b0); // byte done is masked
        rd(`ISFL_OFF_STATUS, 8'ha0, 8'he0);
        addr_byte(7'h2a, 1'b0);
        i_isfl_bus_master.clk_bit(1'b1);
        rd(`ISFL_OFF_STATUS, 8'he0, 8'hff);
        wr(`ISFL_OFF_CTRL1, {seed[7:5], 1'b0, seed[3:0]}); // receive, as the write indication asks
        data_byte(seed[7:0]);
        rd(`ISFL_OFF_DATA, seed[7:0], 8'hff);
        rd(`ISFL_OFF_STATUS, 8'h20, 8'he0);
        i_isfl_bus_master.stop_cond();
        rd(`ISFL_OFF_STATUS, 8'h00, 8'he0);
        $display("test data access done");
        wr(`ISFL_OFF_CTRL2, 8'h01);
        addr_byte(7'h2a, 1'b0);
        i_isfl_bus_master.clk_bit(1'b1);
        rd(`ISFL_OFF_DATA, 8'h00, 8'h00);
        rd(`ISFL_OFF_STATUS, 8'he0, 8'he0);
        @(posedge core_clk);
        int_data_access <= 1'b1;
        @(posedge core_clk);
        int_data_access <= 1'b0;
        rd(`ISFL_OFF_STATUS, 8'h60, 8'he0);
        i_isfl_bus_master.stop_cond();
        $display("test buffered mode done");
        foreach (cases[k]) begin
            wr(`ISFL_OFF_CTRL2, cases[k].c2);
            wr(`ISFL_OFF_SMBC, cases[k].system_mgmt_bus_control_reg);
            wr(`ISFL_OFF_ADDR1, {1'b0, cases[k].a1});
            wr(`ISFL_OFF_RANGE, {1'b0, cases[k].ra});
            wr(`ISFL_OFF_ADDR2, {1'b0, cases[k].a2});
            wr(`ISFL_OFF_CTRL1, 8'h00); // receive, matching the write address below
            addr_byte(cases[k].sent, 1'b0);
            rd(`ISFL_OFF_STATUS, {1'b0, cases[k].hit, 6'h00}, 8'h40);
            i_isfl_bus_master.clk_bit(1'b1);
            i_isfl_bus_master.stop_cond();
        end
        $display("test address table done");
        conclude();
    end
endmodule
`default_nettype wire
